//--- core/cvo_clamp.sv
/*
 Code limiter for one 8-bit sample channel.
 Assumes a combinational path is acceptable; caller registers the result.
*/
`timescale 1ns/10ps
`include "cvo_defines.svh"
module cvo_clamp #(
	parameter logic [7:0] LO = `CVO_CODE_LO,
	parameter logic [7:0] HI = `CVO_CODE_HI
) (
	input wire logic [7:0] din,
	output logic [7:0] dout
);
	// Limits also keep the sync codes 0 and 255 out of the data stream
	assign dout = (din < LO) ? LO : ((din > HI) ? HI : din);
endmodule

//--- core/cvo_strap.sv
/*
 Strap capture: synchronises the multiplexed pins and latches them once after reset.
 Assumes the pins stay undriven by this device until done rises.
*/
`timescale 1ns/10ps
`include "cvo_defines.svh"
module cvo_strap (
	input wire logic pclk,
	input wire logic presetn,
	cvo_strap_if.cap sif
);
	import cvo_pkg::*;
	localparam logic [7:0] HOLD = 8'(`CVO_STRAP_CYC - 1);
	cvo_cap_s r;
	cvo_cap_s n;
	logic [7:0] cp;
	logic [7:0] yp;

	assign cp = r.s2[17:10];
	assign yp = r.s2[9:2];

	always_comb begin
		n = r;
		n.s1 = {sif.c_pin, sif.y_pin, sif.pck_pin, sif.hs_pin};
		n.s2 = r.s1;
		if (!r.done) begin
			// Pins settle for the hold time before the levels are trusted
			if (r.cnt >= HOLD) begin
				n.done = 1'b1;
				n.straps.quarter = cp[2];
				n.straps.emb = cp[1];
				n.straps.sel = {yp[6], yp[4], yp[7]};
				n.straps.colour_bar = yp[0];
				n.straps.pdown = ~r.s2[1];
				n.straps.mono = r.s2[0];
			end else begin
				n.cnt = r.cnt + 8'h01;
			end
		end
		if (sif.clear) begin
			n.cnt = 8'h00;
			n.done = 1'b0;
			n.straps = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign sif.straps = r.straps;
	assign sif.done = r.done;
endmodule

//--- core/cvo_top.sv
/*
 Camera video output port: APB configuration, strap capture, window timing and pixel formatting.
 Assumes the converter presents clamped-or-raw samples on adc_y/adc_c in the pclk domain,
 sampled once per pixel on adc_strobe; pads resolve in/out/oe pin triples.
*/
`timescale 1ns/10ps
`include "cvo_defines.svh"
module cvo_top #(
	parameter logic [6:0] SLAVE_BASE = 7'h2A
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic chip_reset,
	input wire logic multi_slave_select,
	output logic [6:0] slave_id,
	input wire logic [7:0] adc_y,
	input wire logic [7:0] adc_c,
	output logic adc_strobe,
	input wire logic [7:0] luma_in,
	output logic [7:0] luma_out,
	output logic [7:0] luma_oe,
	input wire logic [7:0] chroma_bus_in,
	output logic [7:0] chroma_bus_out,
	output logic [7:0] chroma_bus_oe,
	input wire logic pixclk_in,
	output logic pixclk_out,
	output logic pixclk_oe,
	input wire logic composite_hsync_in,
	output logic composite_hsync_out,
	output logic composite_hsync_oe,
	output logic vsync,
	output logic line_valid
);
	import cvo_pkg::*;

	// Pixel period chosen so the converters never run above their limit
	localparam logic [5:0] PIXC = 6'(`CVO_PIX_CYC);
	// Sensor pixel clock is half its master clock; here the master is pclk / (PIXC / 2)
	localparam int ZV_RATIO = `CVO_ZV_SYS_HZ / `CVO_ZV_PIX_HZ;

	cvo_top_s r;
	cvo_top_s n;
	logic [7:0] y_cl;
	logic [7:0] c_cl;
	logic hit;

	cvo_strap_if sif ();

	cvo_strap u_strap (
		.pclk(pclk),
		.presetn(presetn),
		.sif(sif)
	);

	cvo_clamp u_clamp_y (
		.din(adc_y),
		.dout(y_cl)
	);

	cvo_clamp u_clamp_c (
		.din(adc_c),
		.dout(c_cl)
	);

	assign sif.y_pin = luma_in;
	assign sif.c_pin = chroma_bus_in;
	assign sif.pck_pin = pixclk_in;
	assign sif.hs_pin = composite_hsync_in;
	assign sif.clear = r.cr2;

	// Keeps a window inside the array: size held between 2 and lim, then the start pulled back to fit
	function automatic logic [17:0] sat_win(input logic [8:0] st, input logic [8:0] sz, input logic [8:0] lim);
		logic [8:0] s;
		logic [8:0] p;
		s = (sz < `CVO_MIN_WIN) ? `CVO_MIN_WIN : ((sz > lim) ? lim : sz);
		p = (({1'b0, st} + {1'b0, s}) > {1'b0, lim}) ? 9'(lim - s) : st;
		return {p, s};
	endfunction

	function automatic logic [15:0] bar(input logic [2:0] idx);
		logic [7:0] yb;
		yb = `CVO_CODE_LO + {2'b00, idx, 3'b000} + {3'b000, idx, 2'b00} + {4'b0000, idx, 1'b0} + {5'b00000, idx};
		return {8'(yb + {2'b00, idx, 3'b000}), (idx[0] ? `CVO_CODE_HI : `CVO_CODE_LO)};
	endfunction

	always_comb begin
		hit = (paddr == `CVO_REG_CTRL) || (paddr == `CVO_REG_WINH) || (paddr == `CVO_REG_WINV) ||
			(paddr == `CVO_REG_STAT) || (paddr == `CVO_REG_SLV);
	end

	always_comb begin
		logic [1:0] wlog;
		logic [1:0] wlast;
		logic [5:0] wper;
		logic [8:0] htot;
		logic [8:0] vtot;
		logic [8:0] hlim;
		logic [8:0] vlim;
		logic [8:0] h_end;
		logic in_h;
		logic in_v;
		logic [7:0] yv;
		logic [7:0] cv;
		logic [7:0] nb;
		logic [15:0] cb;
		logic [7:0] xy;
		logic [1:0] sidx;
		logic sav;
		logic eav;
		logic [31:0] rd;
		wlog = 2'd0;
		wlast = 2'd0;
		wper = PIXC;
		htot = `CVO_H_TOTAL;
		vtot = `CVO_V_TOTAL;
		hlim = `CVO_ARRAY_W;
		vlim = `CVO_ARRAY_H;
		h_end = 9'h000;
		in_h = 1'b0;
		in_v = 1'b0;
		yv = 8'h00;
		cv = 8'h00;
		nb = 8'h00;
		cb = 16'h0000;
		xy = 8'h00;
		sidx = 2'd0;
		sav = 1'b0;
		eav = 1'b0;
		rd = 32'h00000000;
		n = r;
		n.cr1 = chip_reset;
		n.cr2 = r.cr1;
		n.ms1 = multi_slave_select;
		n.ms2 = r.ms1;
		n.adc_strobe = 1'b0;

		if (r.cfg.quarter) begin
			hlim = `CVO_ARRAY_W >> 1;
			vlim = `CVO_ARRAY_H >> 1;
		end

		// Read data is staged in the setup cycle so the access phase needs no wait
		if (psel && !penable) begin
			case (paddr)
				`CVO_REG_CTRL: begin
					rd[1:0] = r.cfg.fmt;
					rd[`CVO_CTRL_QUARTER] = r.cfg.quarter;
					rd[`CVO_CTRL_EMB] = r.cfg.emb;
					rd[`CVO_CTRL_COLOUR_BAR] = r.cfg.colour_bar;
					rd[`CVO_CTRL_MONO] = r.cfg.mono;
					rd[`CVO_CTRL_PDOWN] = r.cfg.pdown;
				end
				`CVO_REG_WINH: begin
					rd[8:0] = r.h_start;
					rd[`CVO_WIN_SIZE_LSB +: 9] = r.h_size;
				end
				`CVO_REG_WINV: begin
					rd[8:0] = r.v_start;
					rd[`CVO_WIN_SIZE_LSB +: 9] = r.v_size;
				end
				`CVO_REG_STAT: begin
					rd[0] = (r.phase == cvo_run);
					rd[`CVO_STAT_STRAP_LSB +: 8] = sif.straps;
					rd[`CVO_STAT_LINE_LSB +: 9] = r.lcnt;
				end
				`CVO_REG_SLV: begin
					rd[6:0] = r.slave_id;
				end
				default: begin
					rd = 32'h00000000;
				end
			endcase
			n.prdata = rd;
		end

		if (psel && penable && pwrite) begin
			case (paddr)
				`CVO_REG_CTRL: begin
					n.cfg.fmt = (pwdata[1:0] == 2'h3) ? cvo_fmt16 : cvo_fmt_e'(pwdata[1:0]);
					n.cfg.quarter = pwdata[`CVO_CTRL_QUARTER];
					n.cfg.emb = pwdata[`CVO_CTRL_EMB];
					n.cfg.colour_bar = pwdata[`CVO_CTRL_COLOUR_BAR];
					n.cfg.mono = pwdata[`CVO_CTRL_MONO];
					n.cfg.pdown = pwdata[`CVO_CTRL_PDOWN];
				end
				`CVO_REG_WINH: begin
					{n.h_start, n.h_size} = sat_win(pwdata[8:0], pwdata[`CVO_WIN_SIZE_LSB +: 9], hlim);
				end
				`CVO_REG_WINV: begin
					{n.v_start, n.v_size} = sat_win(pwdata[8:0], pwdata[`CVO_WIN_SIZE_LSB +: 9], vlim);
				end
				default: begin
				end
			endcase
		end

		case (r.phase)
			cvo_boot: begin
				if (sif.done) begin
					// Straps become the starting configuration; later writes override them
					n.cfg.quarter = sif.straps.quarter;
					n.cfg.emb = sif.straps.emb;
					n.cfg.fmt = sif.straps.emb ? cvo_fmt8 : cvo_fmt16;
					n.cfg.colour_bar = sif.straps.colour_bar;
					n.cfg.mono = sif.straps.mono;
					n.cfg.pdown = sif.straps.pdown;
					if (sif.straps.quarter) begin
						{n.h_start, n.h_size} = sat_win(9'd1, `CVO_Q_W, `CVO_ARRAY_W >> 1);
						{n.v_start, n.v_size} = sat_win(9'd1, `CVO_Q_H, `CVO_ARRAY_H >> 1);
					end else begin
						n.h_start = (`CVO_ARRAY_W - `CVO_DEF_W) >> 1;
						n.h_size = `CVO_DEF_W;
						n.v_start = (`CVO_ARRAY_H - `CVO_DEF_H) >> 1;
						n.v_size = `CVO_DEF_H;
					end
					n.phase = cvo_run;
				end
			end
			cvo_run: begin
				// Words per pixel grow with narrower ports; the pixel period does not
				case (r.cfg.fmt)
					cvo_fmt8: wlog = 2'd1;
					cvo_nib: wlog = r.cfg.mono ? 2'd1 : 2'd2;
					default: wlog = 2'd0;
				endcase
				wlast = 2'((3'd1 << wlog) - 3'd1);
				wper = (r.cfg.quarter ? 6'(PIXC << 1) : PIXC) >> wlog;
				if (r.cfg.quarter) begin
					htot = `CVO_H_TOTAL >> 1;
					vtot = `CVO_V_TOTAL >> 1;
				end
				if (r.cfg.pdown) begin
					n.div = 6'd0;
					n.word = 2'd0;
					n.pcnt = 9'h000;
					n.lcnt = 9'h000;
					n.pclk_o = 1'b0;
					n.hs = 1'b0;
					n.vs = 1'b0;
					n.lv = 1'b0;
				end else begin
					if (r.div >= 6'(wper - 6'd1)) begin
						n.div = 6'd0;
						if (r.word >= wlast) begin
							n.word = 2'd0;
							n.adc_strobe = 1'b1;
							n.ysamp = y_cl;
							n.csamp = c_cl;
							// Line and frame totals are fixed, so the window never alters rates
							if (r.pcnt >= 9'(htot - 9'd1)) begin
								n.pcnt = 9'h000;
								n.lcnt = (r.lcnt >= 9'(vtot - 9'd1)) ? 9'h000 : 9'(r.lcnt + 9'd1);
							end else begin
								n.pcnt = 9'(r.pcnt + 9'd1);
							end
						end else begin
							n.word = 2'(r.word + 2'd1);
						end
					end else begin
						n.div = 6'(r.div + 6'd1);
					end
					// A configuration change restarts the word so the clock never rises on new data
					if (n.cfg != r.cfg) begin
						n.div = 6'd0;
						n.word = 2'd0;
					end
					// Clock rises mid-word, after the data has settled for half a word
					n.pclk_o = (n.div >= (wper >> 1));
					in_h = (n.pcnt >= r.h_start) && ({1'b0, n.pcnt} < ({1'b0, r.h_start} + {1'b0, r.h_size}));
					in_v = (n.lcnt >= r.v_start) && ({1'b0, n.lcnt} < ({1'b0, r.v_start} + {1'b0, r.v_size}));
					// Window edits take hold only at a word boundary, never at a clock rise
					if (n.div == 6'd0) begin
						n.lv = in_h && in_v;
					end
					n.hs = (n.pcnt < `CVO_HS_PIX) ^ (n.lcnt < `CVO_VS_LINES);
					n.vs = (n.lcnt < `CVO_VS_LINES);
					cb = bar(n.pcnt[8:6]);
					yv = r.cfg.colour_bar ? cb[15:8] : n.ysamp;
					cv = r.cfg.colour_bar ? cb[7:0] : n.csamp;
					if (!n.lv) begin
						yv = `CVO_CODE_LO;
						cv = `CVO_CHROMA_BLACK;
					end
					case (r.cfg.fmt)
						cvo_fmt8: begin
							n.y_out = n.word[0] ? yv : cv;
							n.c_out = `CVO_CHROMA_BLACK;
						end
						cvo_nib: begin
							nb = (r.cfg.mono || n.word[1]) ? yv : cv;
							n.y_out = {n.word[0] ? nb[3:0] : nb[7:4], 4'h0};
							n.c_out = `CVO_CHROMA_BLACK;
						end
						default: begin
							n.y_out = yv;
							n.c_out = cv;
						end
					endcase
					// Sync words need two pixel slots ahead of the window; a start below 2 gets none
					h_end = 9'(r.h_start + r.h_size);
					sav = (r.h_start >= 9'd2) && ((n.pcnt == 9'(r.h_start - 9'd2)) || (n.pcnt == 9'(r.h_start - 9'd1)));
					eav = (n.pcnt == h_end) || (n.pcnt == 9'(h_end + 9'd1));
					sidx = {(n.pcnt == 9'(r.h_start - 9'd1)) || (n.pcnt == 9'(h_end + 9'd1)), n.word[0]};
					xy = {1'b1, 1'b0, ~in_v, eav, ~in_v ^ eav, eav, ~in_v, ~in_v ^ eav};
					if (r.cfg.emb && (r.cfg.fmt == cvo_fmt8) && (sav || eav)) begin
						case (sidx)
							2'd0: n.y_out = `CVO_SYNC_FF;
							2'd3: n.y_out = xy;
							default: n.y_out = `CVO_SYNC_00;
						endcase
					end
				end
			end
			default: begin
				n.phase = cvo_boot;
			end
		endcase

		// Pins stay released until the straps have been taken
		n.y_oe = (n.phase == cvo_run) ? ((n.cfg.fmt == cvo_nib) ? 8'hF0 : 8'hFF) : 8'h00;
		n.c_oe = (n.phase == cvo_run) && (n.cfg.fmt == cvo_fmt16) && !n.cfg.mono;
		n.k_oe = (n.phase == cvo_run);
		n.slave_id = r.ms2 ? {SLAVE_BASE[6:3], sif.straps.sel} : SLAVE_BASE;

		if (r.cr2) begin
			n = '0;
			n.cr1 = chip_reset;
			n.cr2 = r.cr1;
			// Slave identity keeps following its pin through a chip reset
			n.ms1 = multi_slave_select;
			n.ms2 = r.ms1;
			n.slave_id = r.ms2 ? {SLAVE_BASE[6:3], sif.straps.sel} : SLAVE_BASE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign prdata = r.prdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign slave_id = r.slave_id;
	assign adc_strobe = r.adc_strobe;
	assign luma_out = r.y_out;
	assign luma_oe = r.y_oe;
	assign chroma_bus_out = r.c_out;
	assign chroma_bus_oe = {8{r.c_oe}};
	assign pixclk_out = r.pclk_o;
	assign pixclk_oe = r.k_oe;
	assign composite_hsync_out = r.hs;
	assign composite_hsync_oe = r.k_oe;
	assign vsync = r.vs;
	assign line_valid = r.lv;
endmodule

//--- pkg/cvo_defines.svh
/*
 Constants of the camera video output port: timing, codes, strap hold time and register map.
 Assumes a 200 MHz register clock and an external converter feeding one sample pair per pixel.
*/
`ifndef CVO_DEFINES_SVH
`define CVO_DEFINES_SVH

`define CVO_CLK_HZ 200000000
`define CVO_ADC_MAX_HZ 9000000
`define CVO_PIX_CYC ((((`CVO_CLK_HZ + `CVO_ADC_MAX_HZ - 1) / `CVO_ADC_MAX_HZ + 3) / 4) * 4)
`define CVO_ZV_SYS_HZ 17730000
`define CVO_ZV_PIX_HZ 8860000
`define CVO_STRAP_NS 1000
`define CVO_STRAP_CYC ((`CVO_STRAP_NS * (`CVO_CLK_HZ / 1000000) + 999) / 1000)

`define CVO_ARRAY_W 9'd356
`define CVO_ARRAY_H 9'd292
`define CVO_DEF_W 9'd352
`define CVO_DEF_H 9'd288
`define CVO_Q_W 9'd176
`define CVO_Q_H 9'd144
`define CVO_MIN_WIN 9'd2
`define CVO_H_TOTAL 9'd400
`define CVO_V_TOTAL 9'd312
`define CVO_HS_PIX 9'd16
`define CVO_VS_LINES 9'd3

`define CVO_CODE_LO 8'h10
`define CVO_CODE_HI 8'hF0
`define CVO_CHROMA_BLACK 8'h80
`define CVO_SYNC_FF 8'hFF
`define CVO_SYNC_00 8'h00

`define CVO_REG_CTRL 12'h000
`define CVO_REG_WINH 12'h004
`define CVO_REG_WINV 12'h008
`define CVO_REG_STAT 12'h00C
`define CVO_REG_SLV 12'h010
`define CVO_CTRL_QUARTER 2
`define CVO_CTRL_EMB 3
`define CVO_CTRL_COLOUR_BAR 4
`define CVO_CTRL_MONO 5
`define CVO_CTRL_PDOWN 6
`define CVO_WIN_SIZE_LSB 16
`define CVO_STAT_STRAP_LSB 8
`define CVO_STAT_LINE_LSB 16

`endif

//--- pkg/cvo_pkg.sv
/*
 Types of the camera video output port.
 Assumes the constants header is compiled alongside.
*/
package cvo_pkg;
	typedef enum logic [1:0] {cvo_fmt16, cvo_fmt8, cvo_nib} cvo_fmt_e;
	typedef enum logic {cvo_boot, cvo_run} cvo_phase_e;
	typedef struct packed {
		logic quarter;
		logic emb;
		logic [2:0] sel;
		logic colour_bar;
		logic pdown;
		logic mono;
	} cvo_strap_s;
	typedef struct packed {
		cvo_fmt_e fmt;
		logic quarter;
		logic emb;
		logic colour_bar;
		logic mono;
		logic pdown;
	} cvo_cfg_s;
	typedef struct packed {
		logic [17:0] s1;
		logic [17:0] s2;
		logic [7:0] cnt;
		logic done;
		cvo_strap_s straps;
	} cvo_cap_s;
	typedef struct packed {
		cvo_phase_e phase;
		logic cr1;
		logic cr2;
		logic ms1;
		logic ms2;
		cvo_cfg_s cfg;
		logic [8:0] h_start;
		logic [8:0] h_size;
		logic [8:0] v_start;
		logic [8:0] v_size;
		logic [5:0] div;
		logic [1:0] word;
		logic [8:0] pcnt;
		logic [8:0] lcnt;
		logic [7:0] ysamp;
		logic [7:0] csamp;
		logic [7:0] y_out;
		logic [7:0] c_out;
		logic [7:0] y_oe;
		logic c_oe;
		logic k_oe;
		logic pclk_o;
		logic hs;
		logic vs;
		logic lv;
		logic adc_strobe;
		logic [6:0] slave_id;
		logic [31:0] prdata;
	} cvo_top_s;
endpackage

//--- pkg/cvo_strap_if.sv
/*
 Carrier between the port logic and the strap capture.
 Assumes pin levels arrive raw from the pads.
*/
`timescale 1ns/10ps
interface cvo_strap_if;
	logic [7:0] y_pin;
	logic [7:0] c_pin;
	logic pck_pin;
	logic hs_pin;
	logic clear;
	cvo_pkg::cvo_strap_s straps;
	logic done;
	modport ctl(output y_pin, c_pin, pck_pin, hs_pin, clear, input straps, done);
	modport cap(input y_pin, c_pin, pck_pin, hs_pin, clear, output straps, done);
endinterface

//--- verif/camera_video_output_port_tb.sv
/*
 Testbench of the camera video output port: strap boots, registers, formats and window.
 Assumes pins resolve from output enables against strap resistor levels.
*/
`timescale 1ns/10ps
`include "cvo_defines.svh"
module camera_video_output_port_tb;
	import cvo_pkg::*;
	typedef struct packed {logic [31:0] e; logic [31:0] m; logic er;} cvo_note_s;
	logic pclk, presetn, psel, penable, pwrite, chip_reset, multi_slave_select;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr, adc_strobe, pixclk_out, pixclk_oe, composite_hsync_out, composite_hsync_oe, vsync;
	logic line_valid, pck_strap, hs_strap;
	logic [6:0] slave_id;
	logic [7:0] adc_y, adc_c, luma_out, luma_oe, chroma_bus_out, chroma_bus_oe, y_strap, c_strap, per_cyc;
	logic [9:0] line_len;
	logic [15:0] bad_codes;
	wire logic [7:0] luma_pin = (luma_oe & luma_out) | (~luma_oe & y_strap);
	wire logic [7:0] chroma_pin = (chroma_bus_oe & chroma_bus_out) | (~chroma_bus_oe & c_strap);
	wire logic pck_pin = pixclk_oe ? pixclk_out : pck_strap;
	wire logic hs_pin = composite_hsync_oe ? composite_hsync_out : hs_strap;
	int failed, samples_checked;
	cvo_note_s notes[$];
	cvo_note_s cur;
	cvo_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.chip_reset, .multi_slave_select, .slave_id, .adc_y, .adc_c, .adc_strobe, .luma_in(luma_pin), .luma_out,
		.luma_oe, .chroma_bus_in(chroma_pin), .chroma_bus_out, .chroma_bus_oe, .pixclk_in(pck_pin), .pixclk_out,
		.pixclk_oe, .composite_hsync_in(hs_pin), .composite_hsync_out, .composite_hsync_oe, .vsync, .line_valid);
	cvo_capture_model u_cap (.pclk, .presetn, .pixclk_out, .line_valid, .luma_out, .luma_oe, .chroma_bus_out,
		.chroma_bus_oe, .line_len, .per_cyc, .bad_codes);
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			failed++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wrap_up;
		$display("comparisons %0d mismatches %0d", samples_checked, failed);
		if (failed == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Each transfer leaves its expectation; the monitor judges it at the completing edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e, input logic [31:0] m,
		input logic er);
		int n;
		@(posedge pclk);
		notes.push_back({e, m, er});
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			failed++;
			wrap_up();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
		apb(1'b0, a, 32'h0, e, m, 1'b0);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
	endtask
	task wait_oe;
		int n;
		n = 0;
		while (pixclk_oe !== 1'b1 && n < 1000) begin
			@(posedge pclk);
			n++;
		end
		if (pixclk_oe !== 1'b1) begin
			failed++;
			wrap_up();
		end
	endtask
	function automatic logic [7:0] strap_code();
		return {c_strap[2], c_strap[1], y_strap[6], y_strap[4], y_strap[7], y_strap[0], ~pck_strap, hs_strap};
	endfunction
	always @(posedge pclk) begin
		adc_y <= 8'($urandom);
		adc_c <= 8'($urandom);
		if (psel && penable && pready) begin
			if (notes.size() == 0) chk("apb_queue", 32'h1, 32'h0);
			else begin
				cur = notes.pop_front();
				chk("prdata", cur.e, prdata & cur.m);
				chk("pslverr", {31'h0, cur.er}, {31'h0, pslverr});
			end
		end
	end
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, chip_reset, multi_slave_select} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		{adc_y, adc_c} = 16'h0000;
		// First boot: every strap but slave select bit y_strap[6] set, power down included
		{y_strap, c_strap, pck_strap, hs_strap} = {8'hB5, 8'h06, 1'b0, 1'b1};
		void'($urandom(91414));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		wait_oe();
		rd(`CVO_REG_CTRL, 32'h0000007D);
		rd(`CVO_REG_STAT, {16'h0, strap_code(), 8'h01}, 32'h0000FFFF);
		rd(`CVO_REG_WINH, 32'h00B00001);
		rd(`CVO_REG_WINV, 32'h00900001);
		@(posedge pclk);
		chip_reset <= 1'b1;
		y_strap <= 8'($urandom) & 8'hFE;
		c_strap <= 8'($urandom) & 8'hF9;
		{pck_strap, hs_strap} <= 2'b10;
		repeat (5) @(posedge pclk);
		chip_reset <= 1'b0;
		wait_oe();
		rd(`CVO_REG_CTRL, 32'h0);
		rd(`CVO_REG_STAT, {16'h0, strap_code(), 8'h01}, 32'h0000FFFF);
		rd(`CVO_REG_WINH, 32'h01600002);
		rd(`CVO_REG_WINV, 32'h01200002);
		rd(`CVO_REG_SLV, 32'h0000002A);
		@(posedge pclk);
		multi_slave_select <= 1'b1;
		repeat (4) @(posedge pclk);
		rd(`CVO_REG_SLV, {25'h0, 4'h5, y_strap[6], y_strap[4], y_strap[7]});
		apb(1'b0, 12'h020, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
		apb(1'b1, 12'h014, 32'hFFFFFFFF, 32'h0, 32'h0, 1'b1);
		for (int i = 0; i < 3; i++) begin
			wr(`CVO_REG_CTRL, i);
			rd(`CVO_REG_CTRL, i);
			repeat (80) @(posedge pclk);
			chk("word_period", 32'd24 >> i, per_cyc);
			chk("luma_oe", (i == 2) ? 32'hF0 : 32'hFF, luma_oe);
			chk("chroma_oe", (i == 0) ? 32'hFF : 32'h0, chroma_bus_oe);
		end
		wr(`CVO_REG_CTRL, 32'h0);
		wr(`CVO_REG_WINV, 32'h01240000);
		wr(`CVO_REG_WINH, 32'h0002000A);
		repeat (19300) @(posedge pclk);
		chk("line_len", 32'd2, line_len);
		chk("pixel_period", 32'd24, per_cyc);
		wr(`CVO_REG_WINH, 32'h01640064);
		rd(`CVO_REG_WINH, 32'h01640000);
		repeat (19300) @(posedge pclk);
		chk("line_len", 32'd356, line_len);
		wr(`CVO_REG_CTRL, 32'h14);
		rd(`CVO_REG_CTRL, 32'h14);
		repeat (200) @(posedge pclk);
		chk("quarter_period", 32'd48, per_cyc);
		chk("bad_codes", 32'h0, bad_codes);
		wrap_up();
	end
endmodule

//--- verif/cvo_capture_model.sv
/*
 Capture controller model: latches video at pixel clock rises, measures line length and clock period.
 Assumes pixel clock is slow against pclk, so it is sampled and its edges found here.
*/
`timescale 1ns/10ps
module cvo_capture_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pixclk_out,
	input wire logic line_valid,
	input wire logic [7:0] luma_out,
	input wire logic [7:0] luma_oe,
	input wire logic [7:0] chroma_bus_out,
	input wire logic [7:0] chroma_bus_oe,
	output logic [9:0] line_len,
	output logic [7:0] per_cyc,
	output logic [15:0] bad_codes
);
	import cvo_pkg::*;
	logic prev;
	logic [7:0] cyc;
	logic [9:0] run;
	function automatic logic bad(input logic [7:0] v);
		return v < 8'h10 || v > 8'hF0;
	endfunction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev <= 1'b0;
			cyc <= 8'h00;
			run <= 10'h000;
			line_len <= 10'h000;
			per_cyc <= 8'h00;
			bad_codes <= 16'h0000;
		end else begin
			prev <= pixclk_out;
			cyc <= (pixclk_out && !prev) ? 8'h00 : cyc + 8'h01;
			if (pixclk_out && !prev) begin
				per_cyc <= cyc + 8'h01;
				// Nibble words are half codes, so only full-width buses are range checked
				if (line_valid) begin
					run <= run + 10'h001;
					if ((luma_oe == 8'hFF && bad(luma_out)) || (chroma_bus_oe == 8'hFF && bad(chroma_bus_out))) begin
						bad_codes <= bad_codes + 16'h0001;
					end
				end else if (run != 10'h000) begin
					line_len <= run;
					run <= 10'h000;
				end
			end
		end
	end
endmodule

//--- verif/cvo_top_asserts.sv
/*
 Checker for the camera video output port: pin timing, codes, straps and resets.
 Assumes it is bound to cvo_top and sees only its ports.
*/
`timescale 1ns/10ps
module cvo_top_asserts #(
	parameter logic [6:0] SLAVE_BASE = 7'h2A
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pslverr,
	input wire logic chip_reset,
	input wire logic multi_slave_select,
	input wire logic [6:0] slave_id,
	input wire logic adc_strobe,
	input wire logic [7:0] luma_out,
	input wire logic [7:0] luma_oe,
	input wire logic [7:0] chroma_bus_out,
	input wire logic [7:0] chroma_bus_oe,
	input wire logic pixclk_out,
	input wire logic pixclk_oe,
	input wire logic composite_hsync_out,
	input wire logic composite_hsync_oe,
	input wire logic vsync,
	input wire logic line_valid
);
	import cvo_pkg::*;
	logic [7:0] boot_cnt;
	logic [7:0] gap;
	// Both saturate; chip reset restarts the pixel counters, so the gap is voided then
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_cnt <= 8'h00;
			gap <= 8'hFF;
		end else begin
			if (boot_cnt != 8'hFF) boot_cnt <= boot_cnt + 8'h01;
			if (chip_reset) gap <= 8'hFF;
			else if (adc_strobe) gap <= 8'h00;
			else if (gap != 8'hFF) gap <= gap + 8'h01;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_BOOT_OE: assert property (boot_cnt < 8'h96 |-> luma_oe == 8'h00 && chroma_bus_oe == 8'h00
		&& !pixclk_oe && !composite_hsync_oe) else $error("pins driven before strap capture");
	AST_SLV_LO: assert property (!multi_slave_select [*4] |=> slave_id == SLAVE_BASE)
		else $error("single slave identity wrong");
	AST_SLV_HI: assert property (multi_slave_select [*4] |=> slave_id[6:3] == SLAVE_BASE[6:3])
		else $error("multi slave identity base wrong");
	AST_ADC_GAP: assert property (adc_strobe |-> gap >= 8'h16)
		else $error("converter sampled above its rate");
	AST_PCLK_STABLE: assert property ($rose(pixclk_out) |-> $stable(luma_out) && $stable(line_valid)
		&& $stable(chroma_bus_out)) else $error("data moved at pixel clock rise");
	AST_Y_RANGE: assert property (line_valid && chroma_bus_oe == 8'hFF |-> luma_out inside {[8'h10:8'hF0]})
		else $error("luma code out of range");
	AST_C_RANGE: assert property (line_valid && chroma_bus_oe == 8'hFF |-> chroma_bus_out inside {[8'h10:8'hF0]})
		else $error("chroma code out of range");
	AST_VSYNC: assert property ($rose(vsync) |=> vsync [*8])
		else $error("vertical sync pulse too short");
	AST_HSYNC: assert property ($rose(composite_hsync_out) && !vsync |=> composite_hsync_out [*8])
		else $error("composite sync pulse too short");
	AST_NIBBLE: assert property (luma_oe == 8'hF0 |-> chroma_bus_oe == 8'h00)
		else $error("chroma driven in nibble mode");
	AST_CRESET: assert property (chip_reset [*5] |=> luma_oe == 8'h00 && chroma_bus_oe == 8'h00
		&& !line_valid && !pixclk_oe) else $error("chip reset did not clear outputs");
	AST_SLVERR: assert property (psel && penable && paddr > 12'h010 |-> pslverr)
		else $error("unmapped access not refused");
endmodule
bind cvo_top cvo_top_asserts #(.SLAVE_BASE(SLAVE_BASE)) u_asserts (.pclk, .presetn, .psel, .penable, .paddr,
	.pslverr, .chip_reset, .multi_slave_select, .slave_id, .adc_strobe, .luma_out, .luma_oe, .chroma_bus_out,
	.chroma_bus_oe, .pixclk_out, .pixclk_oe, .composite_hsync_out, .composite_hsync_oe, .vsync, .line_valid);
